/* shared/annunciator_defs.svh */
// constants for the alarm annunciator: offsets, fields, reset values, timing
`ifndef ANNUNCIATOR_DEFS_SVH
`define ANNUNCIATOR_DEFS_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLOCK_MHZ 125
`define LAMP_TEST_MS 1000
`define FLASH_HALF_MS 500
`define STAMP_TICK_MS 100
`define LAMP_TEST_CYCLES (`LAMP_TEST_MS * 1000 * `CLOCK_MHZ)
`define FLASH_HALF_CYCLES (`FLASH_HALF_MS * 1000 * `CLOCK_MHZ)
`define STAMP_TICK_CYCLES (`STAMP_TICK_MS * 1000 * `CLOCK_MHZ)
// ----------------------------------------
// sizes
// ----------------------------------------
`define INPUTS 16
`define LAMPS 32
`define LOG_DEPTH 64
`define LOG_WIDTH 54
`define LAST_INPUT 4'hf
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_KEYS 8'h04
`define OFF_STATUS 8'h08
`define OFF_IRQ_STATUS 8'h0c
`define OFF_IRQ_MASK 8'h10
`define OFF_LOG_STAMP 8'h14
`define OFF_LOG_INFO 8'h18
`define OFF_TIME 8'h1c
`define OFF_ALARMS 8'h20
// ----------------------------------------
// key register bits
// ----------------------------------------
`define KEY_SILENCE 0
`define KEY_ACK 1
`define KEY_RESET 2
`define KEY_UP 3
`define KEY_DOWN 4
`define KEY_ESCAPE 5
`define KEY_MENU 6
`define KEY_LOG 7
`define KEY_TEST 8
`define KEY_PREV 9
`define KEY_NEXT 10
`define KEY_CLEAR 11
`define KEY_BITS 12
// ----------------------------------------
// status and interrupt fields
// ----------------------------------------
`define ST_SCREEN 4
`define ST_BUZZER 6
`define ST_TESTING 7
`define ST_PREV 8
`define ST_NEXT 9
`define ST_COUNT 10
`define ST_VIEW 17
`define IRQ_ALARM 0
`define IRQ_LOGGED 1
`define IRQ_TEST_DONE 2
`define IRQ_BITS 3
// ----------------------------------------
// log entry fields and reset values
// ----------------------------------------
`define LOG_STAMP_LSB 22
`define LOG_VALUE_LSB 6
`define LOG_INPUT_LSB 2
`define LOG_SETPOINT 1
`define LOG_INTO_ALARM 0
`define RESET_IRQ_MASK 3'h0
`define RESET_TIME 32'h00000000
`endif

/* shared/annunciator_pkg.sv */
// types for the alarm annunciator
package annunciator_pkg;
  typedef enum logic [1:0] {screen_top, screen_menu, screen_log} screen_type;
  typedef enum logic [1:0] {lamp_off, lamp_flash, lamp_steady} lamp_type;
  typedef enum logic [1:0] {seq_follow, seq_auto, seq_manual} seq_type;
endpackage

/* logic/log_memory.sv */
// history log storage with registered read data
`timescale 1ns/1ps
`include "annunciator_defs.svh"
module log_memory (
  input wire logic clock,
  input wire logic write_enable,
  input wire logic [5:0] write_address,
  input wire logic [`LOG_WIDTH-1:0] write_data,
  input wire logic [5:0] read_address,
  output logic [`LOG_WIDTH-1:0] read_data
);
  logic [`LOG_WIDTH-1:0] store [`LOG_DEPTH];

  always_ff @(posedge clock) begin
    if (write_enable) begin
      store[write_address] <= write_data;
    end
  end

  always_ff @(posedge clock) begin
    read_data <= store[read_address];
  end
endmodule // log_memory

/* logic/alarm_annunciator.sv */
// alarm annunciation, display navigation, lamp test and event history log
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "annunciator_defs.svh"
module alarm_annunciator #(
  parameter int unsigned test_cycles = `LAMP_TEST_CYCLES,
  parameter int unsigned flash_cycles = `FLASH_HALF_CYCLES,
  parameter int unsigned tick_cycles = `STAMP_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [`LAMPS-1:0] setpoint_alarm,
  input wire logic [16*`INPUTS-1:0] input_value,
  output logic [`LAMPS-1:0] lamp_led,
  output logic buzzer,
  output annunciator_pkg::screen_type screen,
  output logic [3:0] selected_input,
  output logic [15:0] shown_value,
  output logic log_prev_offered,
  output logic log_next_offered,
  output logic irq
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // input synchroniser and change detection
  // ----------------------------------------
  logic [`LAMPS-1:0] alarm_meta;
  logic [`LAMPS-1:0] abnormal;
  logic [`LAMPS-1:0] abnormal_q;
  logic [`LAMPS-1:0] rise;
  logic [`LAMPS-1:0] change;
  logic new_alarm;
  logic [4:0] rise_first;

  // lamp 2*i is setpoint 1 of input i, lamp 2*i+1 its setpoint 2
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alarm_meta <= 32'h00000000;
      abnormal <= 32'h00000000;
      abnormal_q <= 32'h00000000;
    end else begin
      alarm_meta <= setpoint_alarm;
      abnormal <= alarm_meta;
      abnormal_q <= abnormal;
    end
  end

  function automatic logic [4:0] lowest_set(input logic [31:0] bits);
    lowest_set = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (bits[i]) begin
        lowest_set = 5'(i);
      end
    end
  endfunction

  assign rise = abnormal & ~abnormal_q;
  assign change = abnormal ^ abnormal_q;
  assign new_alarm = |rise;
  assign rise_first = lowest_set(rise);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic aw_take;
  logic ar_take;
  logic [`KEY_BITS-1:0] keys;
  annunciator_pkg::seq_type seq;
  logic [`IRQ_BITS-1:0] irq_status;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [31:0] stamp;
  logic [31:0] read_word;
  logic read_hit;
  logic write_hit;
  logic [31:0] strobe_bits;
  logic irq_read;

  assign aw_take = awvalid & wvalid & ~bvalid;
  assign awready = aw_take;
  assign wready = aw_take;
  assign ar_take = arvalid & ~rvalid;
  assign arready = ~rvalid;
  assign strobe_bits = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
  assign irq_read = ar_take && araddr == `OFF_IRQ_STATUS;

  always_comb begin
    write_hit = 1'b1;
    if (awaddr == `OFF_CTRL) begin
    end else if (awaddr == `OFF_KEYS) begin
    end else if (awaddr == `OFF_IRQ_MASK) begin
    end else if (awaddr == `OFF_TIME) begin
    end else begin
      write_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bvalid <= 1'b0;
      bresp <= 2'h0;
    end else if (aw_take) begin
      bvalid <= 1'b1;
      bresp <= write_hit ? 2'h0 : 2'h2;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // key writes become one-cycle command pulses
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      keys <= 12'h000;
    end else if (aw_take && awaddr == `OFF_KEYS) begin
      keys <= wdata[`KEY_BITS-1:0] & strobe_bits[`KEY_BITS-1:0];
    end else begin
      keys <= 12'h000;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      seq <= annunciator_pkg::seq_follow;
    end else if (aw_take && awaddr == `OFF_CTRL && wstrb[0]) begin
      if (wdata[1:0] == 2'h0) begin
        seq <= annunciator_pkg::seq_follow;
      end else if (wdata[1:0] == 2'h1) begin
        seq <= annunciator_pkg::seq_auto;
      end else begin
        seq <= annunciator_pkg::seq_manual;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= `RESET_IRQ_MASK;
    end else if (aw_take && awaddr == `OFF_IRQ_MASK && wstrb[0]) begin
      irq_mask <= wdata[`IRQ_BITS-1:0];
    end
  end

  // ----------------------------------------
  // time stamp counter, 100 ms resolution
  // ----------------------------------------
  logic [31:0] tick_count;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_count <= 32'h00000000;
      stamp <= `RESET_TIME;
    end else if (aw_take && awaddr == `OFF_TIME) begin
      tick_count <= 32'h00000000;
      stamp <= (stamp & ~strobe_bits) | (wdata & strobe_bits);
    end else if (tick_count == 32'(tick_cycles - 1)) begin
      tick_count <= 32'h00000000;
      stamp <= stamp + 32'h00000001;
    end else begin
      tick_count <= tick_count + 32'h00000001;
    end
  end

  // ----------------------------------------
  // screens and input selection
  // ----------------------------------------
  logic on_top;
  logic on_menu;
  logic on_log;

  assign on_top = screen == annunciator_pkg::screen_top;
  assign on_menu = screen == annunciator_pkg::screen_menu;
  assign on_log = screen == annunciator_pkg::screen_log;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      screen <= annunciator_pkg::screen_top;
    end else if (new_alarm) begin
      screen <= annunciator_pkg::screen_top;
    end else begin
      case (screen)
        annunciator_pkg::screen_top: begin
          if (keys[`KEY_MENU]) begin
            screen <= annunciator_pkg::screen_menu;
          end
        end
        annunciator_pkg::screen_menu: begin
          if (keys[`KEY_ESCAPE]) begin
            screen <= annunciator_pkg::screen_top;
          end else if (keys[`KEY_LOG]) begin
            screen <= annunciator_pkg::screen_log;
          end
        end
        default: begin
          if (keys[`KEY_ESCAPE]) begin
            screen <= annunciator_pkg::screen_menu;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      selected_input <= 4'h0;
    end else if (new_alarm) begin
      selected_input <= rise_first[4:1];
    end else if (on_top && keys[`KEY_UP] && selected_input != `LAST_INPUT) begin
      selected_input <= selected_input + 4'h1;
    end else if (on_top && keys[`KEY_DOWN] && selected_input != 4'h0) begin
      selected_input <= selected_input - 4'h1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      shown_value <= 16'h0000;
    end else begin
      shown_value <= input_value[16*selected_input +: 16];
    end
  end

  // ----------------------------------------
  // alarm sequences, one per setpoint lamp
  // ----------------------------------------
  logic silence_cmd;
  logic ack_cmd;
  logic reset_cmd;
  annunciator_pkg::lamp_type lamp [`LAMPS];

  assign silence_cmd = on_top & keys[`KEY_SILENCE];
  assign ack_cmd = on_top & keys[`KEY_ACK];
  assign reset_cmd = on_top & keys[`KEY_RESET];

  for (genvar g = 0; g < `LAMPS; g++) begin : seq_lane
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        lamp[g] <= annunciator_pkg::lamp_off;
      end else begin
        case (lamp[g])
          annunciator_pkg::lamp_off: begin
            if (rise[g]) begin
              lamp[g] <= annunciator_pkg::lamp_flash;
            end
          end
          annunciator_pkg::lamp_flash: begin
            if (seq == annunciator_pkg::seq_follow && !abnormal[g]) begin
              lamp[g] <= annunciator_pkg::lamp_off;
            end else if (ack_cmd) begin
              if (abnormal[g] || seq == annunciator_pkg::seq_manual) begin
                lamp[g] <= annunciator_pkg::lamp_steady;
              end else begin
                lamp[g] <= annunciator_pkg::lamp_off;
              end
            end
          end
          default: begin
            if (rise[g]) begin
              lamp[g] <= annunciator_pkg::lamp_flash;
            end else if (!abnormal[g] && (seq != annunciator_pkg::seq_manual || reset_cmd)) begin
              lamp[g] <= annunciator_pkg::lamp_off;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // buzzer, flasher and lamp test
  // ----------------------------------------
  logic buzz;
  logic testing;
  logic test_done;
  logic [31:0] test_count;
  logic [31:0] flash_count;
  logic flash_phase;

  // set wins: an alarm in the silence cycle still sounds
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      buzz <= 1'b0;
    end else if (new_alarm) begin
      buzz <= 1'b1;
    end else if (silence_cmd || ack_cmd) begin
      buzz <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flash_count <= 32'h00000000;
      flash_phase <= 1'b0;
    end else if (flash_count == 32'(flash_cycles - 1)) begin
      flash_count <= 32'h00000000;
      flash_phase <= ~flash_phase;
    end else begin
      flash_count <= flash_count + 32'h00000001;
    end
  end

  assign test_done = testing && test_count == 32'(test_cycles - 1);

  // the test only overrides outputs, so lamp states keep evolving underneath
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      testing <= 1'b0;
      test_count <= 32'h00000000;
    end else if (test_done) begin
      testing <= 1'b0;
      test_count <= 32'h00000000;
    end else if (testing) begin
      test_count <= test_count + 32'h00000001;
    end else if (on_menu && keys[`KEY_TEST]) begin
      testing <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lamp_led <= 32'h00000000;
      buzzer <= 1'b0;
    end else begin
      buzzer <= buzz | testing;
      for (int i = 0; i < `LAMPS; i++) begin
        if (testing) begin
          lamp_led[i] <= 1'b1;
        end else begin
          lamp_led[i] <= lamp[i] == annunciator_pkg::lamp_steady ||
                         (lamp[i] == annunciator_pkg::lamp_flash && flash_phase);
        end
      end
    end
  end

  // ----------------------------------------
  // history log
  // ----------------------------------------
  logic [`LAMPS-1:0] pending;
  logic [4:0] log_lane;
  logic log_write;
  logic clear_cmd;
  logic [5:0] write_ptr;
  logic [6:0] log_count;
  logic [5:0] view_age;
  logic [`LOG_WIDTH-1:0] entry;
  logic [`LOG_WIDTH-1:0] view_entry;

  assign clear_cmd = on_log & keys[`KEY_CLEAR];
  assign log_lane = lowest_set(pending);
  assign log_write = |pending & ~clear_cmd;
  assign entry = {stamp, input_value[16*log_lane[4:1] +: 16], log_lane, abnormal[log_lane]};
  assign log_prev_offered = on_log && 7'(view_age) + 7'h01 < log_count;
  assign log_next_offered = on_log && view_age != 6'h00;

  // one entry per cycle; new changes queue here, set wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending <= 32'h00000000;
    end else begin
      pending <= (pending & ~(log_write ? 32'h00000001 << log_lane : 32'h00000000)) | change;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      write_ptr <= 6'h00;
      log_count <= 7'h00;
    end else if (clear_cmd) begin
      write_ptr <= 6'h00;
      log_count <= 7'h00;
    end else if (log_write) begin
      write_ptr <= write_ptr + 6'h01;
      if (log_count != 7'(`LOG_DEPTH)) begin
        log_count <= log_count + 7'h01;
      end
    end
  end

  // view age counts back from the newest entry
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      view_age <= 6'h00;
    end else if (clear_cmd || (on_menu && keys[`KEY_LOG])) begin
      view_age <= 6'h00;
    end else if (keys[`KEY_PREV] && log_prev_offered) begin
      view_age <= view_age + 6'h01;
    end else if (keys[`KEY_NEXT] && log_next_offered) begin
      view_age <= view_age - 6'h01;
    end
  end

  log_memory history (
    .clock(clock),
    .write_enable(log_write),
    .write_address(write_ptr),
    .write_data(entry),
    .read_address(write_ptr - 6'h01 - view_age),
    .read_data(view_entry)
  );

  // ----------------------------------------
  // interrupts and read path
  // ----------------------------------------
  logic [`IRQ_BITS-1:0] irq_event;

  assign irq_event = {test_done, log_write, new_alarm};

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_read ? 3'h0 : irq_status) | irq_event;
      irq <= |(irq_status & irq_mask);
    end
  end

  always_comb begin
    read_word = 32'h00000000;
    read_hit = 1'b1;
    if (araddr == `OFF_CTRL) begin
      read_word[1:0] = seq;
    end else if (araddr == `OFF_KEYS) begin
      read_word = 32'h00000000;
    end else if (araddr == `OFF_STATUS) begin
      read_word[3:0] = selected_input;
      read_word[`ST_SCREEN +: 2] = screen;
      read_word[`ST_BUZZER] = buzz;
      read_word[`ST_TESTING] = testing;
      read_word[`ST_PREV] = log_prev_offered;
      read_word[`ST_NEXT] = log_next_offered;
      read_word[`ST_COUNT +: 7] = log_count;
      read_word[`ST_VIEW +: 6] = view_age;
    end else if (araddr == `OFF_IRQ_STATUS) begin
      read_word[`IRQ_BITS-1:0] = irq_status;
    end else if (araddr == `OFF_IRQ_MASK) begin
      read_word[`IRQ_BITS-1:0] = irq_mask;
    end else if (araddr == `OFF_LOG_STAMP) begin
      read_word = view_entry[`LOG_STAMP_LSB +: 32];
    end else if (araddr == `OFF_LOG_INFO) begin
      read_word[21:0] = view_entry[21:0];
    end else if (araddr == `OFF_TIME) begin
      read_word = stamp;
    end else if (araddr == `OFF_ALARMS) begin
      read_word = abnormal;
    end else begin
      read_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (ar_take) begin
      rvalid <= 1'b1;
      rdata <= read_word;
      rresp <= read_hit ? 2'h0 : 2'h2;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  buzz_on_alarm_a: assert property (new_alarm |=> buzz ##1 buzzer)
    else $error("buzzer not sounded on new alarm");
  screen_forced_a: assert property (new_alarm |=> on_top)
    else $error("alarm did not force top screen");
  last_input_a: assert property (new_alarm |=> selected_input == $past(rise_first[4:1]))
    else $error("wrong input selected");
  // ack, reset or a level change in the same cycle may move the lamp legally
  silence_quiet_a: assert property (silence_cmd && !ack_cmd && !reset_cmd && !new_alarm && !change[0] |=>
    !buzz && $stable(lamp[0])) else $error("silence failed");
  up_step_a: assert property (on_top && keys[`KEY_UP] && !new_alarm && selected_input < `LAST_INPUT |=>
    selected_input == $past(selected_input) + 4'h1) else $error("up did not step");
  escape_back_a: assert property (on_log && keys[`KEY_ESCAPE] && !new_alarm |=> on_menu)
    else $error("escape did not step back");
  test_lamps_a: assert property ($past(testing) |-> lamp_led == 32'hffffffff && buzzer)
    else $error("lamp test outputs wrong");
  test_length_a: assert property (testing && !test_done |=>
    testing && test_count == $past(test_count) + 32'h00000001) else $error("lamp test ended early");
  // lamp_led is registered, so it shows the lamp state of the previous cycle
  test_resume_a: assert property ($fell(testing) |=>
    $past(lamp[0]) == annunciator_pkg::lamp_flash || lamp_led[0] == ($past(lamp[0]) == annunciator_pkg::lamp_steady))
    else $error("lamp not restored");
  change_logged_a: assert property (|change && !clear_cmd |=> |pending)
    else $error("change not queued");
  full_wraps_a: assert property (log_write && !clear_cmd && log_count == 7'(`LOG_DEPTH) |=>
    log_count == 7'(`LOG_DEPTH) && write_ptr == $past(write_ptr) + 6'h01) else $error("full log mishandled");
  clear_empty_a: assert property (clear_cmd |=> log_count == 7'h00 && !log_prev_offered)
    else $error("clear left entries");
  prev_guard_a: assert property (keys[`KEY_PREV] && !log_prev_offered && !keys[`KEY_CLEAR] &&
    !keys[`KEY_NEXT] && !keys[`KEY_LOG] |=> $stable(view_age)) else $error("prev moved past oldest");
endmodule // alarm_annunciator

/* testbench/machine_inputs.sv */
// machine side model: setpoint levels and input values
`timescale 1ns/1ps
module machine_inputs (
  input wire logic clock,
  input wire logic [31:0] trip,
  output logic [31:0] setpoint_alarm,
  output logic [255:0] input_value
);
  // levels move just after an edge, as a scanned input module would
  always_ff @(posedge clock) begin
    setpoint_alarm <= trip;
  end
  // distinct values so log entries can be told apart
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      input_value[16*i +: 16] = 16'h0100 + 16'(i);
    end
  end
endmodule // machine_inputs

/* testbench/alarm_annunciator_event_log_tb.sv */
// bench for the alarm annunciator
`timescale 1ns/1ps
`include "annunciator_defs.svh"
module alarm_annunciator_event_log_tb;
  logic clock, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] ws;
  logic awready, wready, bvalid, arready, rvalid, buzzer, pv, nx, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, trip, sa, led, r;
  logic [1:0] bresp, rresp;
  logic [255:0] iv;
  annunciator_pkg::screen_type screen;
  logic [3:0] sel;
  logic [15:0] shown;
  int n_errors, checked;
  machine_inputs u_mach (.clock(clock), .trip(trip), .setpoint_alarm(sa), .input_value(iv));
  alarm_annunciator #(.test_cycles(20), .flash_cycles(4), .tick_cycles(5)) u_dut (
    .clock(clock), .rstn(rstn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(ws), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .setpoint_alarm(sa), .input_value(iv), .lamp_led(led), .buzzer(buzzer),
    .screen(screen), .selected_input(sel), .shown_value(shown), .log_prev_offered(pv),
    .log_next_offered(nx), .irq(irq));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // ready and the answer are taken at the rising edge; the closing edge keeps the
  // next call from reassigning a strobe in the same time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    awaddr <= a;
    wdata <= d;
    ws <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do @(posedge clock); while (!awready);
    awvalid <= 0;
    wvalid <= 0;
    do @(posedge clock); while (!bvalid);
    bready <= 0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    rready <= 0;
    @(posedge clock);
  endtask
  task automatic key(input int b);
    wr(`OFF_KEYS, 32'h1 << b);
    repeat (2) @(posedge clock);
  endtask
  task automatic test_done;
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic alarm_path;
    wr(`OFF_IRQ_MASK, 32'h1);
    key(`KEY_MENU);
    trip <= 32'h00000800;
    repeat (8) @(posedge clock);
    chk("buzzer", buzzer, 1);
    chk("screen", screen, 0);
    chk("sel", sel, 5);
    chk("irq", irq, 1);
    rd(`OFF_IRQ_STATUS, r);
    chk("irq st", r[2:0], 3'h3);
    repeat (3) @(posedge clock);
    chk("irq clr", irq, 0);
    rd(`OFF_LOG_INFO, r);
    chk("info", r[21:0], 22'h004157);
    key(`KEY_SILENCE);
    chk("silence", buzzer, 0);
    key(`KEY_UP);
    chk("up", sel, 6);
    chk("shown", shown, 16'h0106);
  endtask
  task automatic test_and_log;
    key(`KEY_MENU);
    key(`KEY_TEST);
    chk("test led", led, 32'hffffffff);
    chk("test scr", screen, 1);
    chk("test buz", buzzer, 1);
    repeat (30) @(posedge clock);
    chk("after led", led & 32'hfffff7ff, 0);
    chk("after buz", buzzer, 0);
    key(`KEY_ESCAPE);
    chk("esc", screen, 0);
    trip <= 0;
    repeat (8) @(posedge clock);
    rd(`OFF_STATUS, r);
    chk("count", r[16:10], 2);
    key(`KEY_MENU);
    key(`KEY_LOG);
    chk("offer", 32'(pv) + 32'(nx), 1);
    key(`KEY_CLEAR);
    rd(`OFF_STATUS, r);
    chk("clear", r[16:10], 0);
    rd(8'hfc, r);
    chk("unmapped", 32'(rresp), 2);
    wr(8'hfc, 0);
    chk("bresp", 32'(bresp), 2);
    wr(`OFF_IRQ_MASK, 32'h7, 4'h0);
    rd(`OFF_IRQ_MASK, r);
    chk("strobe", r, 1);
  endtask
  // 65 changes spaced so none coalesce, then the manual reset sequence on lamp 0
  task automatic fill_and_sequence;
    trip <= 32'hffffffff;
    repeat (40) @(posedge clock);
    trip <= 0;
    repeat (40) @(posedge clock);
    trip <= 32'h00000001;
    repeat (8) @(posedge clock);
    rd(`OFF_STATUS, r);
    chk("full", r[16:10], 7'h40);
    rd(`OFF_LOG_INFO, r);
    chk("newest", r[21:0], 22'h004001);
    wr(`OFF_CTRL, 2);
    key(`KEY_ACK);
    chk("ack buz", buzzer, 0);
    trip <= 0;
    repeat (8) @(posedge clock);
    chk("held", led[0], 1);
    key(`KEY_RESET);
    chk("reset", led[0], 0);
  endtask
  initial begin
    rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; trip = 0;
    ws = 4'hf;
    repeat (16) @(posedge clock);
    rstn <= 1;
    @(posedge clock);
    alarm_path();
    test_and_log();
    fill_and_sequence();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    test_done();
  end
endmodule // alarm_annunciator_event_log_tb
